/* File: shared/trap_pkg.sv */
package trap_pkg;

	// Clock and reset-instruction timing
	localparam int CLK_NS          = 25;
	localparam int RESET_INSN_NS   = 8400;
	localparam int RESET_PAUSE_NS  = 150;
	localparam int RESET_INSN_CYC  = (RESET_INSN_NS + CLK_NS - 1) / CLK_NS;
	localparam int RESET_PAUSE_CYC = (RESET_PAUSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_CNT_W       = 9;

	// Status word fields and values
	localparam int         PSW_T_BIT    = 4;
	localparam int         PSW_PRIO_LSB = 5;
	localparam logic [7:0] PSW_HALT     = 8'he0;
	localparam logic [7:0] PSW_RESET    = 8'he0;

	// Trap vectors and PC operand step
	localparam logic [15:0] VEC_ILLEGAL  = 16'h0004;
	localparam logic [15:0] VEC_RESERVED = 16'h0008;
	localparam logic [15:0] VEC_TRACE    = 16'h000c;
	localparam logic [15:0] VEC_PF       = 16'h0014;
	localparam logic [15:0] VEC_LVL4     = 16'h0030;
	localparam logic [15:0] VEC_LVL5     = 16'h0050;
	localparam logic [15:0] VEC_LVL6     = 16'h0040;
	localparam logic [15:0] VEC_LVL7     = 16'h0060;
	localparam logic [15:0] PC_STEP2     = 16'h0004;

	// Opcodes and decode masks
	localparam logic [15:0] OP_RTI      = 16'h0002;
	localparam logic [15:0] OP_RESET    = 16'h0005;
	localparam logic [15:0] OP_RTT      = 16'h0006;
	localparam logic [15:0] JMP_MASK    = 16'hffc0;
	localparam logic [15:0] JMP_CODE    = 16'h0040;
	localparam logic [15:0] JSR_MASK    = 16'hfe00;
	localparam logic [15:0] JSR_CODE    = 16'h0800;
	localparam logic [15:0] EIS_MASK    = 16'hf800;
	localparam logic [15:0] EIS_CODE    = 16'h7000;
	localparam logic [15:0] ESC_LO      = 16'h7a20;
	localparam logic [15:0] ESC_HI      = 16'h7bff;
	localparam logic [15:0] MAINT_MASK  = 16'hfff8;
	localparam logic [15:0] MAINT_CODE  = 16'h0088;
	localparam logic [15:0] FLT_MASK    = 16'hf000;
	localparam logic [15:0] FLT_CODE    = 16'hf000;
	localparam logic [2:0]  MODE_REG    = 3'h0;
	localparam logic [2:0]  MODE_AUTOINC = 3'h2;
	localparam logic [2:0]  MODE_INDEX  = 3'h6;
	localparam logic [2:0]  OPC_NONE    = 3'h0;
	localparam logic [2:0]  OPC_WIDE    = 3'h7;
	localparam logic [5:0]  SRC_PC      = 6'h07;

	// APB register map
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_MASK   = 8'h04;
	localparam logic [7:0] OFF_STATE  = 8'h08;
	localparam logic [7:0] OFF_LASTV  = 8'h0c;

	// Event bits in status and mask
	localparam int EV_W        = 6;
	localparam int EV_INSN     = 0;
	localparam int EV_TRACE    = 1;
	localparam int EV_DEV      = 2;
	localparam int EV_HALT     = 3;
	localparam int EV_PF       = 4;
	localparam int EV_RSTDONE  = 5;
	localparam logic [EV_W-1:0] MASK_RESET = 6'h00;

	typedef enum logic [1:0] {
		RST_IDLE,
		RST_INIT,
		RST_PAUSE
	} rst_state_e;

endpackage

/* File: hdl/trap_unit.sv */
`timescale 1ns/1ps
// Functional notes
// RULE_01: PC source, indexed destination stores address+4
// RULE_02: Autoincrement jump uses pre-increment register value
// RULE_03: Register-mode jump or call traps to 4
// RULE_04: Addresses 177700-177717 are plain external addresses
// RULE_05: Reset insn 8.4us plus 150ns, power-fail held
// RULE_06: Return-from-trace trace trap after next insn
// RULE_07: Return-from-interrupt trace trap taken immediately
// RULE_08: Trace beats interrupts; tracing blocks device interrupts
// RULE_09: Trace trap acknowledged before concurrent interrupt
// RULE_10: Pending trace trap ends wait
// RULE_11: Trace flag loaded only by implicit loads
// RULE_12: Stack pointer odd/missing addresses never trap
// RULE_13: Higher interrupt may preempt service routine entry
// RULE_14: Status word reached only by move instructions
// RULE_15: Four coded lines decode to four levels
// RULE_16: No stack-overflow or odd-address trap
// RULE_17: Extended arithmetic reserved; listed extras supported
// RULE_18: Halt loads restart address and status 340
module trap_unit
	import trap_pkg::*;
#(
	parameter logic [7:0] PROC_TYPE_CODE = 8'h5a // Arbitrary value
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic [3:0]  cp,
	input  wire logic        halt_pin,
	input  wire logic        pf_pin,
	input  wire logic        insn_valid,
	input  wire logic [15:0] opcode,
	input  wire logic [15:0] insn_addr,
	input  wire logic [15:0] reg_value,
	input  wire logic        insn_end,
	input  wire logic        waiting,
	input  wire logic        vector_done,
	input  wire logic [15:0] restart_addr,
	input  wire logic [7:0]  new_psw,
	input  wire logic        psw_load_implicit,
	input  wire logic        psw_load_explicit,
	input  wire logic        cc_load,
	input  wire logic [3:0]  cc,
	input  wire logic        mem_req,
	input  wire logic [15:0] mem_addr,
	output logic             trap_take,
	output logic      [15:0] trap_vector,
	output logic             trap_fixed,
	output logic             wait_release,
	output logic      [7:0]  processor_status_word,
	output logic      [15:0] opnd_pc_value,
	output logic             opnd_pc_valid,
	output logic      [15:0] jump_target,
	output logic             jump_target_valid,
	output logic             init_out,
	output logic             reset_busy,
	output logic             reset_done,
	output logic             mem_ext_req,
	output logic      [15:0] mem_ext_addr,
	output logic      [7:0]  proc_type
);

	logic [5:0]      pin_s1_r;
	logic [5:0]      pin_s2_r;
	logic            halt_d_r;
	logic            pf_d_r;
	logic [3:0]      cp_s;
	logic            is_jump;
	logic            illegal;
	logic            reserved;
	logic            is_rti_r;
	logic            is_rtt_r;
	logic            insn_trap_r;
	logic [15:0]     insn_vec_r;
	logic            trace_pend_r;
	logic            trace_now;
	logic            in_trace_svc_r;
	logic            halt_pend_r;
	logic            pf_pend_r;
	logic            vec_busy_r;
	rst_state_e      rst_state_r;
	logic [RST_CNT_W-1:0] rst_cnt_r;
	logic [2:0]      dev_level;
	logic [15:0]     dev_vec;
	logic            dev_ok;
	logic            arb_ok;
	logic            take;
	logic [15:0]     take_vec;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] status_r;
	logic [EV_W-1:0] mask_r;
	logic [15:0]     last_vec_r;
	logic            rst_done_ev;
	logic            apb_wr;
	logic            apb_hit;
	logic [31:0]     rd_mux;

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			halt_d_r <= 1'b0;
			pf_d_r   <= 1'b0;
		end else begin
			pin_s1_r <= {pf_pin, halt_pin, cp};
			pin_s2_r <= pin_s1_r;
			halt_d_r <= pin_s2_r[4];
			pf_d_r   <= pin_s2_r[5];
		end
	end
	assign cp_s = pin_s2_r[3:0];

	// Coded priority decode
	always_comb begin
		dev_level = 3'h0;
		dev_vec   = 16'h0000;
		if (cp_s != 4'h0) begin
			dev_level = 3'h4 + {1'b0, cp_s[3:2]}; // RULE_15
			case (cp_s[3:2])
				2'h0: dev_vec = VEC_LVL4 + {12'h000, cp_s[1:0] - 2'h1, 2'h0};
				2'h1: dev_vec = VEC_LVL5 + {12'h000, cp_s[1:0], 2'h0};
				2'h2: dev_vec = VEC_LVL6 + {12'h000, cp_s[1:0], 2'h0};
				default: dev_vec = VEC_LVL7 + {12'h000, cp_s[1:0], 2'h0};
			endcase
		end
	end

	// Instruction decode
	assign is_jump = ((opcode & JMP_MASK) == JMP_CODE) || ((opcode & JSR_MASK) == JSR_CODE);
	assign illegal = is_jump && (opcode[5:3] == MODE_REG); // RULE_03
	assign reserved = ((opcode & EIS_MASK) == EIS_CODE) // RULE_17
		|| (opcode >= ESC_LO && opcode <= ESC_HI)
		|| ((opcode & MAINT_MASK) == MAINT_CODE)
		|| ((opcode & FLT_MASK) == FLT_CODE);
	assign proc_type = PROC_TYPE_CODE; // RULE_17

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			is_rti_r    <= 1'b0;
			is_rtt_r    <= 1'b0;
			insn_trap_r <= 1'b0;
			insn_vec_r  <= 16'h0000;
		end else if (insn_valid) begin
			is_rti_r    <= (opcode == OP_RTI);
			is_rtt_r    <= (opcode == OP_RTT);
			insn_trap_r <= illegal || reserved;
			insn_vec_r  <= illegal ? VEC_ILLEGAL : VEC_RESERVED; // RULE_03
		end
	end

	// Operand helpers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opnd_pc_value     <= 16'h0000;
			opnd_pc_valid     <= 1'b0;
			jump_target       <= 16'h0000;
			jump_target_valid <= 1'b0;
		end else begin
			opnd_pc_valid     <= insn_valid && opcode[14:12] != OPC_NONE
				&& opcode[14:12] != OPC_WIDE && opcode[11:6] == SRC_PC
				&& opcode[5:3] >= MODE_INDEX;
			jump_target_valid <= insn_valid && is_jump && opcode[5:3] == MODE_AUTOINC;
			if (insn_valid) begin
				opnd_pc_value <= insn_addr + PC_STEP2; // RULE_01
				jump_target   <= reg_value; // RULE_02
			end
		end
	end

	// External access path, no internal register window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ext_req  <= 1'b0;
			mem_ext_addr <= 16'h0000;
		end else begin
			mem_ext_req  <= mem_req; // RULE_04 RULE_14 RULE_12 RULE_16
			mem_ext_addr <= mem_addr;
		end
	end

	// Reset instruction sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_state_r <= RST_IDLE;
			rst_cnt_r   <= '0;
			rst_done_ev <= 1'b0;
		end else begin
			rst_done_ev <= 1'b0;
			case (rst_state_r)
				RST_IDLE: begin
					if (insn_valid && opcode == OP_RESET) begin
						rst_state_r <= RST_INIT;
						rst_cnt_r   <= RST_CNT_W'(RESET_INSN_CYC - 1); // RULE_05
					end
				end
				RST_INIT: begin
					if (rst_cnt_r == '0) begin
						rst_state_r <= RST_PAUSE;
						rst_cnt_r   <= RST_CNT_W'(RESET_PAUSE_CYC - 1); // RULE_05
					end else begin
						rst_cnt_r <= rst_cnt_r - 1'b1;
					end
				end
				RST_PAUSE: begin
					if (rst_cnt_r == '0) begin
						rst_state_r <= RST_IDLE;
						rst_done_ev <= 1'b1;
					end else begin
						rst_cnt_r <= rst_cnt_r - 1'b1;
					end
				end
				default: rst_state_r <= RST_IDLE;
			endcase
		end
	end
	assign init_out   = (rst_state_r == RST_INIT);
	assign reset_busy = (rst_state_r != RST_IDLE);
	assign reset_done = rst_done_ev;

	// Trap arbitration
	assign trace_now = trace_pend_r
		|| (insn_end && is_rti_r && processor_status_word[PSW_T_BIT]); // RULE_07
	assign dev_ok = dev_level > processor_status_word[7:PSW_PRIO_LSB]
		&& !processor_status_word[PSW_T_BIT] && !in_trace_svc_r; // RULE_08
	assign arb_ok = vector_done || (!vec_busy_r && (insn_end || waiting)); // RULE_13

	always_comb begin
		take     = 1'b0;
		take_vec = 16'h0000;
		ev       = '0;
		if (arb_ok) begin
			if (insn_trap_r && insn_end) begin
				take         = 1'b1;
				take_vec     = insn_vec_r;
				ev[EV_INSN]  = 1'b1;
			end else if (halt_pend_r) begin
				take         = 1'b1;
				take_vec     = restart_addr; // RULE_18
				ev[EV_HALT]  = 1'b1;
			end else if (trace_now) begin
				take         = 1'b1; // RULE_09 RULE_10
				take_vec     = VEC_TRACE;
				ev[EV_TRACE] = 1'b1;
			end else if (dev_ok) begin
				take         = 1'b1;
				take_vec     = dev_vec;
				ev[EV_DEV]   = 1'b1;
			end else if (pf_pend_r && rst_state_r == RST_IDLE) begin
				take         = 1'b1; // RULE_05
				take_vec     = VEC_PF;
				ev[EV_PF]    = 1'b1;
			end
		end
		ev[EV_RSTDONE] = rst_done_ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_take    <= 1'b0;
			trap_vector  <= 16'h0000;
			trap_fixed   <= 1'b0;
			wait_release <= 1'b0;
			vec_busy_r   <= 1'b0;
			last_vec_r   <= 16'h0000;
		end else begin
			trap_take    <= take;
			trap_fixed   <= take && ev[EV_HALT];
			wait_release <= take && waiting; // RULE_10
			if (take) begin
				trap_vector <= take_vec;
				last_vec_r  <= take_vec;
			end
			if (take) begin
				vec_busy_r <= 1'b1;
			end else if (vector_done) begin
				vec_busy_r <= 1'b0;
			end
		end
	end

	// Pending flags, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trace_pend_r   <= 1'b0;
			in_trace_svc_r <= 1'b0;
			halt_pend_r    <= 1'b0;
			pf_pend_r      <= 1'b0;
		end else begin
			if ((insn_valid && processor_status_word[PSW_T_BIT])
				|| (insn_end && is_rti_r && processor_status_word[PSW_T_BIT] && !ev[EV_TRACE])) begin
				trace_pend_r <= 1'b1; // RULE_06 RULE_07
			end else if (ev[EV_TRACE]) begin
				trace_pend_r <= 1'b0;
			end
			if (ev[EV_TRACE]) begin
				in_trace_svc_r <= 1'b1; // RULE_08
			end else if (insn_end && (is_rti_r || is_rtt_r)) begin
				in_trace_svc_r <= 1'b0;
			end
			if (pin_s2_r[4] && !halt_d_r) begin
				halt_pend_r <= 1'b1;
			end else if (ev[EV_HALT]) begin
				halt_pend_r <= 1'b0;
			end
			if (pin_s2_r[5] && !pf_d_r) begin
				pf_pend_r <= 1'b1;
			end else if (ev[EV_PF]) begin
				pf_pend_r <= 1'b0;
			end
		end
	end

	// Status word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			processor_status_word <= PSW_RESET;
		end else if (ev[EV_HALT]) begin
			processor_status_word <= PSW_HALT; // RULE_18
		end else if (psw_load_implicit) begin
			processor_status_word <= new_psw; // RULE_11
		end else if (psw_load_explicit) begin
			processor_status_word <= {new_psw[7:PSW_T_BIT+1],
				processor_status_word[PSW_T_BIT], new_psw[PSW_T_BIT-1:0]}; // RULE_11 RULE_14
		end else if (cc_load) begin
			processor_status_word <= {processor_status_word[7:PSW_T_BIT], cc};
		end
	end

	// APB slave
	assign apb_wr  = psel && penable && pwrite;
	assign apb_hit = paddr == OFF_STATUS || paddr == OFF_MASK
		|| paddr == OFF_STATE || paddr == OFF_LASTV;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !apb_hit;

	always_comb begin
		case (paddr)
			OFF_STATUS: rd_mux = {26'h0000_000, status_r};
			OFF_MASK:   rd_mux = {26'h0000_000, mask_r};
			OFF_STATE:  rd_mux = {15'h0000, rst_state_r, halt_pend_r, pf_pend_r,
				in_trace_svc_r, trace_pend_r, dev_level, processor_status_word};
			OFF_LASTV:  rd_mux = {16'h0000, last_vec_r};
			default:    rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= '0;
			mask_r   <= MASK_RESET;
		end else begin
			if (apb_wr && paddr == OFF_STATUS) begin
				status_r <= (status_r & ~pwdata[EV_W-1:0]) | ev;
			end else begin
				status_r <= status_r | ev;
			end
			if (apb_wr && paddr == OFF_MASK) begin
				mask_r <= pwdata[EV_W-1:0];
			end
		end
	end
	assign irq = |(status_r & mask_r);

endmodule

/* File: tb/trap_chk_sva.sv */
`timescale 1ns/1ps
module trap_chk
	import trap_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        insn_valid,
	input wire logic [15:0] opcode,
	input wire logic [15:0] insn_addr,
	input wire logic [15:0] reg_value,
	input wire logic        insn_end,
	input wire logic        mem_req,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] restart_addr,
	input wire logic        psw_load_explicit,
	input wire logic        trap_take,
	input wire logic [15:0] trap_vector,
	input wire logic        trap_fixed,
	input wire logic        wait_release,
	input wire logic [7:0]  processor_status_word,
	input wire logic [15:0] opnd_pc_value,
	input wire logic        opnd_pc_valid,
	input wire logic [15:0] jump_target,
	input wire logic        jump_target_valid,
	input wire logic        init_out,
	input wire logic        reset_busy,
	input wire logic        reset_done,
	input wire logic        mem_ext_req,
	input wire logic [15:0] mem_ext_addr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [8:0] init_cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			init_cnt_r <= '0;
		else if (init_out)
			init_cnt_r <= init_cnt_r + 9'h001;
		else
			init_cnt_r <= '0;
	end
	a_pc_operand: assert property (opnd_pc_valid |-> opnd_pc_value == $past(insn_addr) + PC_STEP2)
		else $error("pc operand value wrong");
	a_jump_target: assert property (jump_target_valid |-> jump_target == $past(reg_value))
		else $error("jump target not pre-increment value");
	a_reg_jump: assert property (insn_valid && opcode[5:3] == MODE_REG &&
		((opcode & JMP_MASK) == JMP_CODE || (opcode & JSR_MASK) == JSR_CODE) ##2 insn_end
		|=> trap_take && trap_vector == VEC_ILLEGAL) else $error("register jump did not trap");
	a_mem_pass: assert property (mem_req |=> mem_ext_req && mem_ext_addr == $past(mem_addr))
		else $error("memory reference not passed out");
	a_init_len: assert property ($fell(init_out) |-> init_cnt_r >= RESET_INSN_CYC)
		else $error("reset init too short");
	a_pause_done: assert property ($fell(init_out) |-> !reset_done [*6] ##[0:3] reset_done)
		else $error("reset pause wrong");
	a_pf_held: assert property (reset_busy |-> !(trap_take && trap_vector == VEC_PF))
		else $error("power fail taken during reset");
	a_halt_load: assert property (trap_fixed |-> trap_take && trap_vector == restart_addr
		&& processor_status_word == PSW_HALT) else $error("halt load wrong");
	a_trace_wins: assert property (trap_take && !trap_fixed &&
		$past(processor_status_word[PSW_T_BIT]) |-> trap_vector < VEC_LVL4)
		else $error("device served while tracing");
	a_t_kept: assert property (psw_load_explicit |=> processor_status_word[PSW_T_BIT] ==
		$past(processor_status_word[PSW_T_BIT])) else $error("explicit load changed trace flag");
	a_wait_rel: assert property (wait_release |-> trap_take)
		else $error("wait released without trap");
	a_pc_flag: assert property (insn_valid && opcode[14:12] == 3'h1 && opcode[11:6] == SRC_PC
		&& opcode[5:3] == MODE_INDEX |=> opnd_pc_valid) else $error("pc operand flag missing");
	a_jump_flag: assert property (insn_valid && (opcode & JMP_MASK) == JMP_CODE
		&& opcode[5:3] == MODE_AUTOINC |=> jump_target_valid) else $error("jump target flag missing");
endmodule

/* File: tb/cpu_trace_trap_and_operand_rules_tb.sv */
`timescale 1ns/1ps
module cpu_trace_trap_and_operand_rules_tb
	import trap_pkg::*;
;
	localparam logic [15:0] RST_A = 16'h2004;
	localparam logic [15:0] NOP = 16'h00a0;
	localparam logic [15:0] TOP [5] = '{16'h0041, 16'h09c2, 16'h7000, 16'hf123, 16'h0088};
	localparam logic [15:0] TVEC [5] = '{VEC_ILLEGAL, VEC_ILLEGAL, VEC_RESERVED, VEC_RESERVED,
		VEC_RESERVED};
	localparam logic [15:0] MA [4] = '{16'hffc1, 16'hfffe, 16'h0001, 16'hffff};
	localparam logic [3:0] DC [3] = '{4'h1, 4'h5, 4'h9};
	localparam logic [15:0] DV [3] = '{16'h0030, 16'h0054, 16'h0044};
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, halt_pin = 0, pf_pin = 0;
	logic insn_valid = 0, insn_end = 0, waiting = 0, vector_done = 0, mem_req = 0, cc_load = 0;
	logic psw_load_implicit = 0, psw_load_explicit = 0, err_v;
	logic [7:0] paddr = 0, new_psw = 0, processor_status_word, proc_type;
	logic [31:0] pwdata = 0, prdata, rd_v;
	logic [3:0] cp = 0, cc = 0;
	logic [15:0] opcode = 0, insn_addr = 0, reg_value = 0, mem_addr = 0, restart_addr = RST_A;
	logic pready, pslverr, irq, trap_take, trap_fixed, wait_release, opnd_pc_valid;
	logic jump_target_valid, init_out, reset_busy, reset_done, mem_ext_req;
	logic [15:0] trap_vector, opnd_pc_value, jump_target, mem_ext_addr;
	int fails = 0, checked = 0, init_cyc = 0, k;
	trap_unit #(.PROC_TYPE_CODE(8'h3c)) DUT (.*); // Arbitrary type code
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) if (init_out === 1'b1) init_cyc++;
	task automatic wrap_up;
		$display("fails=%0d checked=%0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic tmo;
		fails++;
		wrap_up();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) tmo();
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd_v, e);
		chk(err_v, a > OFF_LASTV);
	endtask
	task automatic insn(input logic [15:0] op, input logic [15:0] ia, rv, input logic [8:0] ps);
		opcode <= op; insn_addr <= ia; reg_value <= rv; insn_valid <= 1'b1;
		@(posedge pclk);
		insn_valid <= 1'b0; new_psw <= ps[7:0]; psw_load_implicit <= ps[8];
		@(posedge pclk);
		psw_load_implicit <= 1'b0; insn_end <= 1'b1;
		@(posedge pclk);
		insn_end <= 1'b0;
	endtask
	task automatic take(input logic [15:0] v, input logic [3:0] nc, input logic [8:0] ps);
		int i;
		for (i = 0; i < 40 && trap_take !== 1'b1; i++)
			@(posedge pclk);
		if (i == 40) tmo();
		chk(trap_vector, v);
		chk(trap_fixed, v == RST_A);
		chk(wait_release, waiting);
		cp <= nc;
		repeat (3) @(posedge pclk);
		vector_done <= 1'b1; new_psw <= ps[7:0]; psw_load_implicit <= ps[8];
		@(posedge pclk);
		vector_done <= 1'b0; psw_load_implicit <= 1'b0;
	endtask
	task automatic quiet(input int n);
		int c;
		c = 0;
		repeat (n) begin
			@(posedge pclk);
			if (trap_take !== 1'b0) c++;
		end
		chk(c, 0);
	endtask
	task automatic mref(input logic [15:0] a);
		mem_req <= 1'b1; mem_addr <= a;
		@(posedge pclk);
		mem_req <= 1'b0;
		@(posedge pclk);
		chk(mem_ext_addr, a);
		chk(mem_ext_req, 1);
	endtask
	initial begin
		repeat (100000) @(posedge pclk);
		tmo();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFF_MASK, 0);
		rd(OFF_STATUS, 0);
		rd(8'h10, 0);
		chk(proc_type, 8'h3c);
		chk(processor_status_word, PSW_RESET);
		insn(16'h11f7, 16'h1000, 0, 0);
		chk(opnd_pc_value, 16'h1004);
		quiet(4);
		insn(16'h0053, 0, 16'h2222, 0);
		chk(jump_target, 16'h2222);
		insn(16'h0952, 0, 16'h3334, 0);
		chk(jump_target, 16'h3334);
		for (k = 0; k < 5; k++) begin
			insn(TOP[k], 0, 0, 0);
			take(TVEC[k], 0, 0);
		end
		chk(irq, 0);
		wr(OFF_MASK, 1);
		chk(irq, 1);
		wr(OFF_STATUS, 1);
		chk(irq, 0);
		for (k = 0; k < 4; k++) mref(MA[k]);
		quiet(4);
		cp <= 4'hf;
		insn(NOP, 0, 0, 0);
		quiet(4);
		insn(NOP, 0, 0, 9'h100);
		take(16'h006c, 0, 9'h100);
		for (k = 0; k < 3; k++) begin
			cp <= DC[k];
			repeat (3) @(posedge pclk);
			insn(NOP, 0, 0, 0);
			take(DV[k], 0, 9'h100);
		end
		cp <= 4'h1;
		repeat (3) @(posedge pclk);
		insn(NOP, 0, 0, 0);
		take(16'h0030, 4'h8, 9'h100);
		take(16'h0040, 4'h0, 9'h100);
		cp <= 4'h5;
		repeat (3) @(posedge pclk);
		insn(OP_RTI, 0, 0, 9'h110);
		take(VEC_TRACE, 4'h5, 9'h100);
		insn(NOP, 0, 0, 9'h100);
		quiet(6);
		insn(OP_RTT, 0, 0, 9'h110);
		quiet(6);
		insn(NOP, 0, 0, 0);
		take(VEC_TRACE, 0, 9'h100);
		insn(OP_RTT, 0, 0, 9'h110);
		opcode <= 16'h0001;
		insn_valid <= 1'b1;
		@(posedge pclk);
		insn_valid <= 1'b0;
		waiting <= 1'b1;
		take(VEC_TRACE, 0, 9'h100);
		waiting <= 1'b0;
		insn(OP_RTI, 0, 0, 9'h100);
		quiet(4);
		new_psw <= 8'h1f;
		psw_load_explicit <= 1'b1;
		@(posedge pclk);
		psw_load_explicit <= 1'b0;
		@(posedge pclk);
		chk(processor_status_word, 8'h0f);
		insn(NOP, 0, 0, 9'h100);
		halt_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		insn(NOP, 0, 0, 0);
		take(RST_A, 0, 0);
		chk(processor_status_word, PSW_HALT);
		halt_pin <= 1'b0;
		insn(OP_RESET, 0, 0, 0);
		chk(reset_busy, 1);
		pf_pin <= 1'b1;
		for (k = 0; k < 500 && reset_done !== 1'b1; k++) @(posedge pclk);
		if (k == 500) tmo();
		chk(init_cyc >= RESET_INSN_CYC, 1);
		chk(reset_busy, 0);
		pf_pin <= 1'b0;
		insn(NOP, 0, 0, 0);
		take(VEC_PF, 0, 0);
		wr(OFF_LASTV, 32'h0000_ffff);
		rd(OFF_LASTV, 32'h0000_0014);
		rd(OFF_STATUS, 32'h0000_003e);
		wr(OFF_MASK, 32'h0000_003f);
		chk(irq, 1);
		wr(OFF_STATUS, 32'h0000_003f);
		chk(irq, 0);
		rd(OFF_STATUS, 0);
		rd(OFF_STATE, {24'h00_0000, PSW_HALT});
		wrap_up();
	end
endmodule
bind trap_unit trap_chk u_chk (.*);
